// ===== bench/mcs_chk.sv
// Concurrent checks on the sync sequencer ports
`default_nettype none
module mcs_chk
    import mcs_pkg::*;
#(
    parameter int PHASE_ALIGN_CYCLES = PHASE_ALIGN_DEFAULT_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic syncPin,
    input wire logic synthRetune,
    input wire logic clkSourceRef,
    input wire logic phaseAlignBusy,
    input wire logic syncFinished
);
    timeunit 1ns;
    timeprecision 1ps;
    logic addrPhase;
    logic cmdWr;
    logic rdMiss;
    logic [3:0] cmdAge;
    logic [4:0] pinAge;
    logic [16:0] tuneAge;
    // Command writes and unmapped reads
    assign addrPhase = hsel && htrans[1] && hready;
    assign cmdWr = addrPhase && hwrite && haddr == {24'h0, CMD_OFFSET};
    assign rdMiss = addrPhase && !hwrite && haddr != 32'h0 && haddr != 32'h4 && haddr != 32'h8;
    // Saturating ages since command, pin high and retune
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cmdAge <= 4'hf;
            pinAge <= 5'h1f;
            tuneAge <= 17'h1ffff;
        end else begin
            cmdAge <= cmdWr ? 4'h0 : cmdAge + {3'h0, cmdAge != 4'hf};
            pinAge <= syncPin ? 5'h0 : pinAge + {4'h0, pinAge != 5'h1f};
            tuneAge <= synthRetune ? 17'h0 : tuneAge + {16'h0, tuneAge != 17'h1ffff};
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence busyStart;
        synthRetune ##2 $rose(phaseAlignBusy);
    endsequence
    okay_bus_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    unmapped_read_a: assert property (rdMiss |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    ref_on_cmd_a: assert property ($rose(clkSourceRef) |-> cmdAge <= 4'h3)
        else $error("ref clock without command");
    ready_clears_a: assert property ($rose(clkSourceRef) |-> ##[0:2] !syncFinished)
        else $error("finished kept after sync");
    fast_clk_a: assert property ($fell(clkSourceRef) |-> pinAge <= 5'h0c)
        else $error("fast clock without pulse");
    finish_pulse_a: assert property ($rose(syncFinished) |->
        pinAge <= 5'h0c && !clkSourceRef) else $error("finished without pulse or on ref clock");
    finished_hold_a: assert property ($fell(syncFinished) |-> cmdAge <= 4'h4)
        else $error("finished dropped");
    busy_cause_a: assert property ($rose(phaseAlignBusy) |-> $past(synthRetune, 2))
        else $error("alignment without retune");
    busy_length_a: assert property ($fell(phaseAlignBusy) |->
        tuneAge == 17'(PHASE_ALIGN_CYCLES + 1)) else $error("alignment length wrong");
    busy_seen_c: cover property (busyStart);
endmodule // mcs_chk
bind multichip_sync_sequencer mcs_chk #(.PHASE_ALIGN_CYCLES(PHASE_ALIGN_CYCLES)) chk (
    .core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .hrdata, .syncPin, .synthRetune, .clkSourceRef, .phaseAlignBusy, .syncFinished);
`default_nettype wire

// ===== bench/sync_pulse_source.sv
// Controller model: free running reference clock and sync pulse train
`default_nettype none
module sync_pulse_source #(
    parameter int WIDTH_CYCLES = 3,
    parameter int SHORT_WAIT_NS = 1100,
    parameter int LONG_WAIT_NS = 100100
) (
    output logic refClk,
    output logic syncLine
);
    timeunit 1ns;
    timeprecision 1ps;
    // Reference clock at one eighth of the core rate, line idles low
    initial begin
        refClk = 1'b0;
        syncLine = 1'b0;
        forever #16 refClk = ~refClk;
    end
    // One pulse, edges clear of both clock edges
    task automatic sendPulse(input int idx);
        @(posedge refClk);
        #8 syncLine = 1'b1;
        repeat (WIDTH_CYCLES) @(posedge refClk);
        #8 syncLine = 1'b0;
        #((idx == 4 || idx == 5) ? LONG_WAIT_NS : SHORT_WAIT_NS);
    endtask
endmodule // sync_pulse_source
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the multichip sync sequencer
`default_nettype none
module tb_top
    import mcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PA_CYCLES = 20;
    logic core_clk, reset_n, hsel, hwrite, hreadyout, hresp, calibrated, synthRetune;
    logic refClkPin, syncPin, clkSourceRef, phaseAlignBusy, syncFinished;
    logic [31:0] haddr, hwdata, hrdata, rdVal;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] badCtrl[4] = '{32'h0, 32'h3, 32'h11, 32'hf2};
    int miscompares, samplesChecked;
    multichip_sync_sequencer #(.PHASE_ALIGN_CYCLES(PA_CYCLES)) dut (
        .core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .refClkPin, .syncPin, .calibrated,
        .synthRetune, .clkSourceRef, .phaseAlignBusy, .syncFinished);
    sync_pulse_source src (.refClk(refClkPin), .syncLine(syncPin));
    // Core clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Bounded wait for hready
    task automatic waitReady();
        int n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            complete_run();
        end
    endtask
    // One word transfer after an idle cycle
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitReady();
        rdVal = hrdata;
    endtask
    task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(rdVal, exp);
    endtask
    function automatic logic [31:0] stat(input logic [1:0] sub, input logic [2:0] sw,
        input logic [8:0] fl, input logic err, input logic [2:0] cnt);
        return {12'h0, cnt, sub == substate_ready || sub == substate_in_progress,
            1'b0, err, fl, sw, sub};
    endfunction
    // Retune, then count busy cycles
    task automatic retune(input int exp);
        int n = 0;
        @(posedge core_clk);
        synthRetune <= 1'b1;
        @(posedge core_clk);
        synthRetune <= 1'b0;
        repeat (PA_CYCLES + 10) begin
            @(posedge core_clk);
            #1;
            if (phaseAlignBusy === 1'b1) n++;
        end
        check(32'(n), 32'(exp));
    endtask
    // Six pulses with status checks, then a surplus pulse
    task automatic runTrain(input logic diff);
        logic [8:0] fl;
        logic [1:0] sub;
        logic [2:0] sw;
        fl = 9'h0;
        rdChk(32'h8, stat(substate_ready, sw_status_ready, fl, 1'b0, 3'h0));
        check({31'h0, clkSourceRef}, 32'h1);
        for (int k = 1; k <= 6; k++) begin
            src.sendPulse(k);
            case (k)
                1: fl[7:4] = {diff, diff, 2'h3};
                2: fl[0] = 1'b1;
                3: fl[1] = 1'b1;
                4: fl[7:2] = 6'h01;
                5: fl = fl | {2'h2, diff, 3'h3, 3'h0};
                default: fl[7:5] = {diff, fl[6], 1'b1};
            endcase
            sub = (k == 1) ? substate_ready : (k == 6) ? substate_finished : substate_in_progress;
            sw = (k == 1) ? sw_status_ready : (k == 6) ? sw_status_on_fast_clock : 3'(k);
            rdChk(32'h8, stat(sub, sw, fl, 1'b0, 3'(k)));
            check({31'h0, clkSourceRef}, {31'h0, k < 5});
        end
        check({31'h0, syncFinished}, 32'h1);
        src.sendPulse(7);
        rdChk(32'h8, stat(substate_finished, sw_status_on_fast_clock, fl, 1'b0, 3'h6));
    endtask
    // Main sequence
    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        calibrated = 1'b1;
        synthRetune = 1'b0;
        miscompares = 0;
        samplesChecked = 0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        #1 check({29'h0, clkSourceRef, phaseAlignBusy, syncFinished}, 32'h0);
        rdChk(32'h0, 32'h0);
        rdChk(32'h8, 32'h0);
        xfer(32'hc, 1'b1, 32'hffff_ffff);
        rdChk(32'hc, 32'h0);
        rdChk(32'h4, 32'h0);
        $display("test reset_and_map done");
        foreach (badCtrl[i]) begin
            xfer(32'h0, 1'b1, badCtrl[i]);
            xfer(32'h4, 1'b1, 32'h1);
            rdChk(32'h8, 32'h0000_4000);
            xfer(32'h4, 1'b1, 32'h4);
            rdChk(32'h8, 32'h0);
        end
        $display("test refusal done");
        xfer(32'h0, 1'b1, 32'h201);
        xfer(32'h4, 1'b1, 32'h1);
        runTrain(1'b1);
        retune(0);
        $display("test delay_only done");
        xfer(32'h0, 1'b1, 32'h102);
        xfer(32'h4, 1'b1, 32'h1);
        runTrain(1'b0);
        retune(PA_CYCLES);
        xfer(32'h4, 1'b1, 32'h2);
        rdChk(32'h8, stat(substate_finished, sw_status_on_fast_clock, 9'h13f, 1'b0,
            3'h6));
        xfer(32'h4, 1'b1, 32'h1);
        rdChk(32'h8, stat(substate_finished, sw_status_on_fast_clock, 9'h13f, 1'b1,
            3'h6));
        calibrated <= 1'b0;
        repeat (5) @(posedge core_clk);
        check({31'h0, syncFinished}, 32'h1);
        $display("test phase_mode done");
        reset_n <= 1'b0;
        calibrated <= 1'b1;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        calibrated <= 1'b0;
        @(posedge core_clk);
        calibrated <= 1'b1;
        xfer(32'h0, 1'b1, 32'h1);
        xfer(32'h4, 1'b1, 32'h1);
        rdChk(32'h8, 32'h0000_4000);
        $display("test recalibrated done");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire

// ===== design/mcs_pkg.sv
// Constants shared by the multichip synchronisation sequencer files
// Behaviour
// - Enabled synchronisation makes RF to serial interface latency deterministic everywhere.
// - Three modes: off (code 0), delay only, delay plus synthesizer phase.
// - Delay-only mode synchronises once, from the first calibrated state, until reset; the code still accepts a new sync from finished.
// - Phase mode realigns synthesizer phase by itself after every retune; the code does so only in the finished or primed state.
// - Hops realign phase in phase mode; delay-only hops add no time.
// - Entering ready switches clock to reference and readies pulse logic.
// - A sync command with power saving above zero is refused with error.
// - In-progress substate is reported while pulses run and before completion.
// - Pulse two flags reference dividers synced; pulse three modulator dividers.
// - Pulse four flags digital clocks and dividers synced, status fourth pulse.
// - Pulse five switches back to synthesizer clock and reports fast clock.
// - Pulse five flags synth sync, first digital and differential interface sync.
// - Pulse six flags second digital and interface sync, then finished.
// - Alignment flags may read true after pulse one; pulse four clears them.
// - Finished substate waits for prime or a fresh sync command.
// - Finished substate stays reported after completion until reinitialisation.
// - Sync starts only from the first calibrated state; leaving it forbids sync.
// - Pulses last at least two reference cycles; waits follow each pulse.
// - Pulses are sampled on a selectable reference clock edge.
`default_nettype none
package mcs_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CMD_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PSAVE_LSB = 4;
    localparam int CTRL_EDGE_BIT = 8;
    localparam int CTRL_DIFF_BIT = 9;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    // Command register bits
    localparam int CMD_SYNC_BIT = 0;
    localparam int CMD_PRIME_BIT = 1;
    localparam int CMD_CLRERR_BIT = 2;
    // Mode settings
    localparam logic [1:0] sync_off_setting = 2'h0;
    localparam logic [1:0] sync_delay_only_setting = 2'h1;
    localparam logic [1:0] sync_with_phase_setting = 2'h2;
    // Reported substate codes
    localparam logic [1:0] substate_none = 2'h0;
    localparam logic [1:0] substate_ready = 2'h1;
    localparam logic [1:0] substate_in_progress = 2'h2;
    localparam logic [1:0] substate_finished = 2'h3;
    // Software status codes
    localparam logic [2:0] sw_status_idle = 3'h0;
    localparam logic [2:0] sw_status_ready = 3'h1;
    localparam logic [2:0] sw_status_second_pulse = 3'h2;
    localparam logic [2:0] sw_status_third_pulse = 3'h3;
    localparam logic [2:0] sw_status_fourth_pulse = 3'h4;
    localparam logic [2:0] sw_status_on_fast_clock = 3'h5;
    // Pulse timing and count
    localparam int MIN_PULSE_REF_CYCLES = 2;
    localparam logic [2:0] PULSES_IN_TRAIN = 3'h6;
    localparam int PHASE_ALIGN_DEFAULT_CYCLES = 1000;
    // Sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_READY, SEQ_PROGRESS, SEQ_FINISHED, SEQ_PRIMED
    } seq_state_type;
endpackage
`default_nettype wire

// ===== design/multichip_sync_sequencer.sv
// Multichip synchronisation sequencer with AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`default_nettype none
module multichip_sync_sequencer
    import mcs_pkg::*;
#(
    parameter int PHASE_ALIGN_CYCLES = PHASE_ALIGN_DEFAULT_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic refClkPin,
    input wire logic syncPin,
    input wire logic calibrated,
    input wire logic synthRetune,
    output logic clkSourceRef,
    output logic phaseAlignBusy,
    output logic syncFinished
);

    // Bus phase capture
    logic wrPending_reg;
    logic [7:0] wrAddr_reg;

    // Address decode
    logic addrPhase;
    logic wordAccess;
    logic [7:0] addrLow;

    // Software visible state
    logic [9:0] ctrl_reg;
    logic error_reg;

    // Control fields
    logic [1:0] modeSetting;
    logic [3:0] powerSave;
    logic edgeFalling;
    logic diffInterface;

    // Sequencer state
    seq_state_type state_reg;
    seq_state_type state_next;
    logic [2:0] pulseCount_reg;
    logic [2:0] swStatus_reg;

    // Status flags
    logic refDivSync_reg;
    logic modDivSync_reg;
    logic digClkSync_reg;
    logic synthSync_reg;
    logic digFirst_reg;
    logic digSecond_reg;
    logic ifFirst_reg;
    logic ifSecond_reg;
    logic onFastClock_reg;

    // Calibrated-state tracking
    logic calPrev_reg;
    logic calSeen_reg;
    logic calLost_reg;

    // Decoded events
    logic cmdWrite;
    logic syncCmd;
    logic primeCmd;
    logic clrErrCmd;
    logic syncAllowed;
    logic syncAccept;
    logic syncReject;

    // Pulse and retune events
    logic pulseEvent;
    logic [2:0] pulseNumber;
    logic inTrain;
    logic retuneAlign;
    logic timerBusy;

    // Reported status
    logic [1:0] substateCode;
    logic [31:0] statusWord;
    logic [31:0] readWord;

    // Address phase decode; only aligned word transfers touch registers
    assign addrPhase = hsel && htrans[1] && hready;
    assign addrLow = haddr[7:0];
    assign wordAccess = (hsize == 3'h2) && (haddr[1:0] == 2'h0) && (haddr[31:8] == 24'h0);

    // Control fields
    assign modeSetting = ctrl_reg[CTRL_MODE_LSB +: 2];
    assign powerSave = ctrl_reg[CTRL_PSAVE_LSB +: 4];
    assign edgeFalling = ctrl_reg[CTRL_EDGE_BIT];
    assign diffInterface = ctrl_reg[CTRL_DIFF_BIT];

    // Command strobes come from the write data phase
    assign cmdWrite = wrPending_reg && (wrAddr_reg == CMD_OFFSET);
    assign syncCmd = cmdWrite && hwdata[CMD_SYNC_BIT];
    assign primeCmd = cmdWrite && hwdata[CMD_PRIME_BIT];
    assign clrErrCmd = cmdWrite && hwdata[CMD_CLRERR_BIT];

    // Sync may start only from the first calibrated state, from idle or finished
    assign syncAllowed = (modeSetting != sync_off_setting) && (modeSetting != 2'h3) &&
                         (powerSave == 4'h0) && calibrated && calSeen_reg &&
                         !calLost_reg &&
                         (state_reg == SEQ_IDLE || state_reg == SEQ_FINISHED);
    assign syncAccept = syncCmd && syncAllowed;
    assign syncReject = syncCmd && !syncAllowed;

    // Pulses count only while a train is expected
    assign inTrain = (state_reg == SEQ_READY) || (state_reg == SEQ_PROGRESS);
    assign pulseNumber = pulseCount_reg + 3'h1;

    // Retune realignment only in phase mode after completion
    assign retuneAlign = synthRetune && (modeSetting == sync_with_phase_setting) &&
                         (state_reg == SEQ_FINISHED || state_reg == SEQ_PRIMED);

    // Pulse sampling on the selected reference edge
    sync_pulse_sampler #(
        .MIN_WIDTH(MIN_PULSE_REF_CYCLES)
    ) pulseSampler (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .refClkPin(refClkPin),
        .syncPin(syncPin),
        .edgeFalling(edgeFalling),
        .pulseEvent(pulseEvent)
    );

    // Phase alignment run time after a hop
    phase_align_timer #(
        .CYCLES(PHASE_ALIGN_CYCLES)
    ) alignTimer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(retuneAlign),
        .busy(timerBusy)
    );

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SEQ_IDLE: begin
                if (syncAccept) state_next = SEQ_READY;
            end
            SEQ_READY: begin
                if (pulseEvent && pulseNumber >= 3'h2) state_next = SEQ_PROGRESS;
            end
            SEQ_PROGRESS: begin
                if (pulseEvent && pulseNumber == PULSES_IN_TRAIN) begin
                    state_next = SEQ_FINISHED;
                end
            end
            SEQ_FINISHED: begin
                if (syncAccept) begin
                    state_next = SEQ_READY;
                end else if (primeCmd) begin
                    state_next = SEQ_PRIMED;
                end
            end
            SEQ_PRIMED: begin
                state_next = SEQ_PRIMED;
            end
        endcase
    end

    // Reported substate; finished stays shown once primed
    assign substateCode = (state_reg == SEQ_READY) ? substate_ready :
                          (state_reg == SEQ_PROGRESS) ? substate_in_progress :
                          (state_reg == SEQ_FINISHED || state_reg == SEQ_PRIMED) ?
                          substate_finished : substate_none;

    // Status word layout
    assign statusWord = {12'h000, pulseCount_reg, (state_reg == SEQ_READY || inTrain),
                         timerBusy, error_reg, onFastClock_reg, ifSecond_reg, ifFirst_reg,
                         digSecond_reg, digFirst_reg, synthSync_reg, digClkSync_reg,
                         modDivSync_reg, refDivSync_reg, swStatus_reg, substateCode};

    // Read mux; unmapped offsets read zero
    assign readWord = (addrLow == CTRL_OFFSET) ? {22'h000000, ctrl_reg} :
                      (addrLow == STATUS_OFFSET) ? statusWord : 32'h00000000;

    // AHB-Lite slave: zero wait states, always OKAY
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wrPending_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
        end else begin
            wrPending_reg <= addrPhase && hwrite && wordAccess;
            wrAddr_reg <= addrLow;
            if (addrPhase && !hwrite) hrdata <= wordAccess ? readWord : 32'h00000000;
        end
    end

    // Control register write
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wrPending_reg && wrAddr_reg == CTRL_OFFSET) begin
            ctrl_reg <= hwdata[9:0];
        end
    end

    // Sticky error; a new rejection wins over a clear
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            error_reg <= 1'b0;
        end else if (syncReject) begin
            error_reg <= 1'b1;
        end else if (clrErrCmd) begin
            error_reg <= 1'b0;
        end
    end

    // First calibrated state tracking
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            calPrev_reg <= 1'b0;
            calSeen_reg <= 1'b0;
            calLost_reg <= 1'b0;
        end else begin
            calPrev_reg <= calibrated;
            if (calibrated) calSeen_reg <= 1'b1;
            if (calPrev_reg && !calibrated) calLost_reg <= 1'b1;
        end
    end

    // State and pulse counter
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= SEQ_IDLE;
            pulseCount_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            if (syncAccept) begin
                pulseCount_reg <= 3'h0;
            end else if (pulseEvent && inTrain) begin
                pulseCount_reg <= pulseNumber;
            end
        end
    end

    // Clock source: reference in ready, synthesizer from pulse five
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            clkSourceRef <= 1'b0;
            onFastClock_reg <= 1'b0;
        end else if (syncAccept) begin
            clkSourceRef <= 1'b1;
            onFastClock_reg <= 1'b0;
        end else if (pulseEvent && inTrain && pulseNumber == 3'h5) begin
            clkSourceRef <= 1'b0;
            onFastClock_reg <= 1'b1;
        end
    end

    // Software status per pulse
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            swStatus_reg <= sw_status_idle;
        end else if (syncAccept) begin
            swStatus_reg <= sw_status_ready;
        end else if (pulseEvent && inTrain) begin
            unique case (pulseNumber)
                3'h2: swStatus_reg <= sw_status_second_pulse;
                3'h3: swStatus_reg <= sw_status_third_pulse;
                3'h4: swStatus_reg <= sw_status_fourth_pulse;
                3'h5: swStatus_reg <= sw_status_on_fast_clock;
                default: swStatus_reg <= swStatus_reg;
            endcase
        end
    end

    // Synthesizer divider sync flags; set with their pulse, cleared by an accepted sync command
    always_ff @(posedge core_clk) begin
        if (!reset_n || syncAccept) begin
            refDivSync_reg <= 1'b0;
            modDivSync_reg <= 1'b0;
            digClkSync_reg <= 1'b0;
            synthSync_reg <= 1'b0;
        end else if (pulseEvent && inTrain) begin
            if (pulseNumber == 3'h2) refDivSync_reg <= 1'b1;
            if (pulseNumber == 3'h3) modDivSync_reg <= 1'b1;
            if (pulseNumber == 3'h4) digClkSync_reg <= 1'b1;
            if (pulseNumber == 3'h5) synthSync_reg <= 1'b1;
        end
    end

    // Alignment flags: settle during early pulses, cleared at four, valid after
    always_ff @(posedge core_clk) begin
        if (!reset_n || syncAccept) begin
            digFirst_reg <= 1'b0;
            digSecond_reg <= 1'b0;
            ifFirst_reg <= 1'b0;
            ifSecond_reg <= 1'b0;
        end else if (pulseEvent && inTrain) begin
            unique case (pulseNumber)
                3'h1: begin
                    digFirst_reg <= 1'b1;
                    digSecond_reg <= 1'b1;
                    ifFirst_reg <= diffInterface;
                    ifSecond_reg <= diffInterface;
                end
                3'h4: begin
                    digFirst_reg <= 1'b0;
                    digSecond_reg <= 1'b0;
                    ifFirst_reg <= 1'b0;
                    ifSecond_reg <= 1'b0;
                end
                3'h5: begin
                    digFirst_reg <= 1'b1;
                    ifFirst_reg <= diffInterface;
                end
                3'h6: begin
                    digSecond_reg <= 1'b1;
                    ifSecond_reg <= diffInterface;
                end
                default: digFirst_reg <= digFirst_reg;
            endcase
        end
    end

    // Outward completion and phase alignment indications
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            syncFinished <= 1'b0;
            phaseAlignBusy <= 1'b0;
        end else begin
            syncFinished <= (state_next == SEQ_FINISHED) || (state_next == SEQ_PRIMED);
            phaseAlignBusy <= timerBusy;
        end
    end
endmodule // multichip_sync_sequencer
`default_nettype wire

// ===== design/phase_align_timer.sv
// Times one synthesizer phase alignment run after a retune
`default_nettype none
module phase_align_timer
    import mcs_pkg::*;
#(
    parameter int CYCLES = PHASE_ALIGN_DEFAULT_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic start,
    output logic busy
);
    initial begin
        if (CYCLES < 1 || CYCLES > 65535) $error("CYCLES out of range");
    end
    logic [15:0] count_reg;
    // A start while busy restarts the run from the full count
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            count_reg <= 16'h0000;
            busy <= 1'b0;
        end else if (start) begin
            count_reg <= 16'(CYCLES);
            busy <= 1'b1;
        end else if (count_reg != 16'h0000) begin
            count_reg <= count_reg - 16'h0001;
            busy <= (count_reg != 16'h0001);
        end
    end
endmodule // phase_align_timer
`default_nettype wire

// ===== design/sync_pulse_sampler.sv
// Samples the sync pin on a chosen reference clock edge and qualifies pulse width
`default_nettype none
module sync_pulse_sampler
    import mcs_pkg::*;
#(
    parameter int MIN_WIDTH = MIN_PULSE_REF_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic refClkPin,
    input wire logic syncPin,
    input wire logic edgeFalling,
    output logic pulseEvent
);
    initial begin
        if (MIN_WIDTH < 1 || MIN_WIDTH > 7) $error("MIN_WIDTH out of range");
    end
    logic [2:0] refSync_reg;
    logic [1:0] pinSync_reg;
    logic [2:0] highCount_reg;
    logic [2:0] highCount_next;
    logic sampleEdge;
    logic qualify;
    // Two-flop synchronisers; the third ref flop only feeds edge detection
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            refSync_reg <= 3'h0;
            pinSync_reg <= 2'h0;
        end else begin
            refSync_reg <= {refSync_reg[1:0], refClkPin};
            pinSync_reg <= {pinSync_reg[0], syncPin};
        end
    end
    // Chosen edge of the reference clock
    assign sampleEdge = edgeFalling ? (refSync_reg[2] & ~refSync_reg[1])
                                    : (~refSync_reg[2] & refSync_reg[1]);
    // Count consecutive high samples, saturating
    assign highCount_next = !pinSync_reg[1] ? 3'h0 :
                            (highCount_reg == 3'h7) ? highCount_reg : highCount_reg + 3'h1;
    assign qualify = sampleEdge && pinSync_reg[1] &&
                     (highCount_next == 3'(MIN_WIDTH)) && (highCount_reg != 3'(MIN_WIDTH));
    // One event per pulse once it has lasted the least width
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            highCount_reg <= 3'h0;
            pulseEvent <= 1'b0;
        end else begin
            if (sampleEdge) highCount_reg <= highCount_next;
            pulseEvent <= qualify;
        end
    end
endmodule // sync_pulse_sampler
`default_nettype wire
